// ---- core/gpio_de_map.svh ----
// Offsets, reset values and widths for the double-edge GPIO logic
// Notes on behaviour
// - Input bit 0 normal; double-edge: rise bit0, fall bit1
// - Output bit 0 normal; double-edge bits muxed per half
// - Output enable optionally registered before pad driver
// - Output and enable registers use launch clock
// - Input registers use capture clock only
// - Unregistered bypass input when no input register
// - Double-edge: both edges, two-bit input word
// - Resync mode moves both bits to rising edge
// - Resync holds falling-edge bit extra half period
// - Differential-pair pins never run double-edge
// - Differential-pair pins never get pull-down
// - Input register edge selectable rising or falling
// - Output register value optionally inverted
// - Bidirectional mode enables all paths independently
`ifndef GPIO_DE_MAP_SVH
`define GPIO_DE_MAP_SVH

// ==========================================================
// Register map
`define ADDR_WIDTH   8
`define DATA_WIDTH   32
`define CFG_OFFSET   8'h00
`define STAT_OFFSET  8'h04
`define CFG_WIDTH    12
`define CFG_RESET    12'h000
`define DATA_ZERO    32'h0000_0000

// ==========================================================
// Synchroniser depth for pad and clock-tree inputs
`define SYNC_STAGES  3

`endif

// ---- core/gpio_de_pkg.sv ----
// Types shared by the double-edge GPIO logic
package gpio_de_pkg;

  typedef enum logic [1:0] {
    MODE_INPUT  = 2'b00,
    MODE_OUTPUT = 2'b01,
    MODE_BIDIR  = 2'b10
  } mode_t;

  // Bit 0 is in_reg; layout follows declaration order from the top
  typedef struct packed {
    mode_t mode;
    logic  pull_down_req;
    logic  diff_pair;
    logic  resync;
    logic  double_edge;
    logic  out_invert;
    logic  oe_reg;
    logic  out_edge_neg;
    logic  out_reg;
    logic  in_edge_neg;
    logic  in_reg;
  } cfg_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } edge_t;

endpackage : gpio_de_pkg

// ---- core/edge_sync.sv ----
// Three-stage synchroniser with agreed level and edge pulses
`include "gpio_de_map.svh"

module edge_sync
  import gpio_de_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  input  wire logic  async_i,
  output edge_t      edge_o
);

  logic [`SYNC_STAGES-1:0] stage_q;
  logic [`SYNC_STAGES-1:0] stage_d;
  edge_t                   edge_q;
  edge_t                   edge_d;
  logic                    agree;

  // ==========================================================
  // Next state
  always_comb
  begin
    stage_d = {stage_q[`SYNC_STAGES-2:0], async_i};
    // Only the last two stages are compared; the first may be metastable
    agree   = (stage_q[1] == stage_q[2]);
    edge_d  = edge_q;
    edge_d.rise = agree && stage_q[2] && !edge_q.level;
    edge_d.fall = agree && !stage_q[2] && edge_q.level;
    if (agree)
    begin
      edge_d.level = stage_q[2];
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      stage_q <= '0;
      edge_q  <= '0;
    end
    else
    begin
      stage_q <= stage_d;
      edge_q  <= edge_d;
    end
  end

  assign edge_o = edge_q;

endmodule : edge_sync

// ---- core/gpio_double_edge_io_logic.sv ----
// Per-pin GPIO logic with double-edge capture and launch
`include "gpio_de_map.svh"

module gpio_double_edge_io_logic
  import gpio_de_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  input  wire logic [`ADDR_WIDTH-1:0]  addr_i,
  input  wire logic [`DATA_WIDTH-1:0]  wdata_i,
  input  wire logic                    we_i,
  input  wire logic                    re_i,
  output logic      [`DATA_WIDTH-1:0]  rdata_o,
  input  wire logic                    capture_clock_i,
  input  wire logic                    launch_clock_i,
  input  wire logic [1:0]              core_out_i,
  input  wire logic                    core_oe_i,
  output logic      [1:0]              core_in_o,
  output logic                         bypass_input_o,
  input  wire logic                    pad_i,
  output logic                         pad_o,
  output logic                         pad_oe_o,
  output logic                         pull_down_o
);

  // ==========================================================
  // Synchronised pad and clock-tree edges
  edge_t pad_e;
  edge_t cap_e;
  edge_t lau_e;

  edge_sync u_pad_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (pad_i),
    .edge_o  (pad_e)
  );

  edge_sync u_cap_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (capture_clock_i),
    .edge_o  (cap_e)
  );

  edge_sync u_lau_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (launch_clock_i),
    .edge_o  (lau_e)
  );

  // ==========================================================
  // State
  cfg_t                   cfg_q;
  cfg_t                   cfg_d;
  logic [`DATA_WIDTH-1:0] rdata_q;
  logic [`DATA_WIDTH-1:0] rdata_d;
  logic [1:0]             core_in_q;
  logic [1:0]             core_in_d;
  logic                   lo_raw_q;
  logic                   lo_raw_d;
  logic                   bypass_q;
  logic                   bypass_d;
  logic                   out_q;
  logic                   out_d;
  logic                   hold_q;
  logic                   hold_d;
  logic                   oe_q;
  logic                   oe_d;
  logic                   pad_q;
  logic                   pad_d;
  logic                   pad_oe_q;
  logic                   pad_oe_d;
  logic                   pull_down_q;
  logic                   pull_down_d;

  logic                   de_eff;
  logic                   in_act;
  logic                   out_act;
  logic                   in_edge;
  logic                   lau_edge;
  logic                   inv;

  // ==========================================================
  // Next state
  always_comb
  begin
    de_eff   = cfg_q.double_edge && !cfg_q.diff_pair;
    in_act   = (cfg_q.mode != MODE_OUTPUT);
    out_act  = (cfg_q.mode != MODE_INPUT);
    in_edge  = cfg_q.in_edge_neg ? cap_e.fall : cap_e.rise;
    lau_edge = cfg_q.out_edge_neg ? lau_e.fall : lau_e.rise;
    inv      = cfg_q.out_invert;

    // Register port
    cfg_d   = cfg_q;
    rdata_d = `DATA_ZERO;
    if (we_i && (addr_i == `CFG_OFFSET))
    begin
      cfg_d = cfg_t'(wdata_i[`CFG_WIDTH-1:0]);
    end
    if (re_i)
    begin
      if (addr_i == `CFG_OFFSET)
      begin
        rdata_d[`CFG_WIDTH-1:0] = cfg_q;
      end
      else if (addr_i == `STAT_OFFSET)
      begin
        rdata_d[5:0] = {pad_e.level, core_in_q, oe_q, pad_oe_q, pad_q};
      end
      else
      begin
        rdata_d = `DATA_ZERO;
      end
    end

    // Input path
    core_in_d = core_in_q;
    lo_raw_d  = lo_raw_q;
    if (!in_act)
    begin
      core_in_d = 2'h0;
    end
    else if (!cfg_q.in_reg)
    begin
      core_in_d = {1'b0, pad_e.level};
    end
    else if (!de_eff)
    begin
      if (in_edge)
      begin
        core_in_d = {1'b0, pad_e.level};
      end
    end
    else if (cfg_q.resync)
    begin
      // Falling-edge bit waits for the next rising edge
      if (cap_e.fall)
      begin
        lo_raw_d = pad_e.level;
      end
      if (cap_e.rise)
      begin
        core_in_d = {lo_raw_q, pad_e.level};
      end
    end
    else
    begin
      if (cap_e.rise)
      begin
        core_in_d[0] = pad_e.level;
      end
      if (cap_e.fall)
      begin
        core_in_d[1] = pad_e.level;
      end
    end
    bypass_d = (in_act && !cfg_q.in_reg) ? pad_e.level : 1'b0;

    // Output path
    out_d  = out_q;
    hold_d = hold_q;
    if (!cfg_q.out_reg)
    begin
      out_d = core_out_i[0];
    end
    else if (!de_eff)
    begin
      if (lau_edge)
      begin
        out_d = core_out_i[0] ^ inv;
      end
    end
    else
    begin
      if (lau_e.rise)
      begin
        out_d  = core_out_i[0] ^ inv;
        hold_d = core_out_i[1] ^ inv;
      end
      if (lau_e.fall)
      begin
        out_d = cfg_q.resync ? hold_q : (core_out_i[1] ^ inv);
      end
    end

    // Enable path
    oe_d = oe_q;
    if (!cfg_q.oe_reg)
    begin
      oe_d = core_oe_i;
    end
    else if (lau_edge)
    begin
      oe_d = core_oe_i;
    end

    // Pad drive; value always follows out_q, enable needs a non-input mode
    pad_d       = out_q;
    pad_oe_d    = out_act && oe_q;
    pull_down_d = cfg_q.pull_down_req && !cfg_q.diff_pair;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_q       <= cfg_t'(`CFG_RESET);
      rdata_q     <= `DATA_ZERO;
      core_in_q   <= 2'h0;
      lo_raw_q    <= 1'b0;
      bypass_q    <= 1'b0;
      out_q       <= 1'b0;
      hold_q      <= 1'b0;
      oe_q        <= 1'b0;
      pad_q       <= 1'b0;
      pad_oe_q    <= 1'b0;
      pull_down_q <= 1'b0;
    end
    else
    begin
      cfg_q       <= cfg_d;
      rdata_q     <= rdata_d;
      core_in_q   <= core_in_d;
      lo_raw_q    <= lo_raw_d;
      bypass_q    <= bypass_d;
      out_q       <= out_d;
      hold_q      <= hold_d;
      oe_q        <= oe_d;
      pad_q       <= pad_d;
      pad_oe_q    <= pad_oe_d;
      pull_down_q <= pull_down_d;
    end
  end

  assign rdata_o        = rdata_q;
  assign core_in_o      = core_in_q;
  assign bypass_input_o = bypass_q;
  assign pad_o          = pad_q;
  assign pad_oe_o       = pad_oe_q;
  assign pull_down_o    = pull_down_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_bypass_only_unreg;
    cfg_q.in_reg |=> !bypass_input_o;
  endproperty
  a_bypass_only_unreg: assert property (p_bypass_only_unreg)
    else $error("Bypass input active while input register selected");

  property p_unreg_in_follows_pad;
    (in_act && !cfg_q.in_reg) |=> (core_in_o == {1'b0, $past(pad_e.level)});
  endproperty
  a_unreg_in_follows_pad: assert property (p_unreg_in_follows_pad)
    else $error("Unregistered input does not follow pad");

  property p_no_de_on_diff;
    cfg_q.diff_pair |-> !de_eff;
  endproperty
  a_no_de_on_diff: assert property (p_no_de_on_diff)
    else $error("Double-edge active on differential-pair pin");

  property p_no_pd_on_diff;
    (cfg_q.diff_pair && $stable(cfg_q)) |=> !pull_down_o;
  endproperty
  a_no_pd_on_diff: assert property (p_no_pd_on_diff)
    else $error("Pull-down selected on differential-pair pin");

  property p_resync_present;
    (in_act && cfg_q.in_reg && de_eff && cfg_q.resync && cap_e.rise)
      |=> (core_in_o == {$past(lo_raw_q), $past(pad_e.level)});
  endproperty
  a_resync_present: assert property (p_resync_present)
    else $error("Resync word not presented on rising edge");

  property p_resync_hold_on_fall;
    (in_act && cfg_q.in_reg && de_eff && cfg_q.resync && cap_e.fall && !cap_e.rise)
      |=> $stable(core_in_o);
  endproperty
  a_resync_hold_on_fall: assert property (p_resync_hold_on_fall)
    else $error("Resync input changed on falling edge");

  property p_sdr_out_invert;
    (cfg_q.out_reg && !de_eff && lau_edge)
      |=> (out_q == ($past(core_out_i[0]) ^ $past(cfg_q.out_invert)));
  endproperty
  a_sdr_out_invert: assert property (p_sdr_out_invert)
    else $error("Registered output value or inversion wrong");

  property p_oe_to_pad;
    (out_act && oe_q) |=> pad_oe_o;
  endproperty
  a_oe_to_pad: assert property (p_oe_to_pad)
    else $error("Pad not driven while enable asserted");

  property p_oe_direct;
    (!cfg_q.oe_reg && out_act && $stable(cfg_q)) ##1 $stable(cfg_q)
      |=> (pad_oe_o == $past(core_oe_i, 2));
  endproperty
  a_oe_direct: assert property (p_oe_direct)
    else $error("Direct enable does not reach pad in two cycles");

  c_de_input:  cover property (in_act && cfg_q.in_reg && de_eff && cap_e.fall);
  c_de_output: cover property (cfg_q.out_reg && de_eff && lau_e.fall && pad_oe_o);
  c_bypass:    cover property (bypass_input_o);
  c_resync:    cover property (de_eff && cfg_q.resync && cap_e.rise);

endmodule : gpio_double_edge_io_logic

// ---- dv/fabric.sv ----
// Core-fabric model: capture and launch clocks, output data and enable
module fabric #(
  parameter int HOLD = 8
)
(
  input  wire logic       clk_i,
  output logic            capture_clock_o,
  output logic            launch_clock_o,
  output logic      [1:0] core_out_o,
  output logic            core_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    capture_clock_o = 1'h0;
    launch_clock_o  = 1'h0;
    core_out_o      = 2'h0;
    core_oe_o       = 1'h0;
  end

  // ==========================================================
  // Clock phases
  // Phases outlast the three-flop sampler; raise HOLD to act slowly
  task automatic cap(input logic v);
    @(posedge clk_i);
    capture_clock_o <= v;
    repeat (HOLD) @(posedge clk_i);
  endtask : cap

  task automatic lch(input logic v);
    @(posedge clk_i);
    launch_clock_o <= v;
    repeat (HOLD) @(posedge clk_i);
  endtask : lch

  // Bit 0 feeds the rising half, bit 1 the falling half
  task automatic drv(input logic [1:0] d, input logic oe);
    @(posedge clk_i);
    core_out_o <= d;
    core_oe_o  <= oe;
    repeat (HOLD) @(posedge clk_i);
  endtask : drv
endmodule : fabric

// ---- dv/tb_top.sv ----
// Self-checking bench for the double-edge GPIO logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i, rstn_i, we_i, re_i, pad_q, pad_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [1:0]  core_out_i, core_in_o;
  logic        capture_clock_i, launch_clock_i, core_oe_i, bypass_input_o;
  logic        pad_o, pad_oe_o, pull_down_o;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // Pad wire: design drives it while enabled, else the outside source
  assign pad_i = pad_oe_o ? pad_o : pad_q;

  fabric fabric_i (
    .clk_i           (clk_i),
    .capture_clock_o (capture_clock_i),
    .launch_clock_o  (launch_clock_i),
    .core_out_o      (core_out_i),
    .core_oe_o       (core_oe_i)
  );

  gpio_double_edge_io_logic gpio_double_edge_io_logic_i (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .we_i            (we_i),
    .re_i            (re_i),
    .rdata_o         (rdata_o),
    .capture_clock_i (capture_clock_i),
    .launch_clock_i  (launch_clock_i),
    .core_out_i      (core_out_i),
    .core_oe_i       (core_oe_i),
    .core_in_o       (core_in_o),
    .bypass_input_o  (bypass_input_o),
    .pad_i           (pad_i),
    .pad_o           (pad_o),
    .pad_oe_o        (pad_oe_o),
    .pull_down_o     (pull_down_o)
  );

  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================
  // Helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value at %0t: %s", $time, m);
      miscompares++;
    end
  endtask : chk

  // Settle time covers the registered outputs after a config change
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we_i    <= 1'h1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i    <= 1'h0;
    repeat (6) @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    re_i   <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    re_i   <= 1'h0;
    #1 d = rdata_o;
  endtask : rd

  task automatic pin(input logic v);
    @(posedge clk_i);
    pad_q <= v;
    repeat (8) @(posedge clk_i);
  endtask : pin

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] d;
    chk(32'(pad_oe_o), 32'h0, "oe reset");
    rd(8'h00, d);
    chk(d, 32'h0, "cfg reset");
    @(posedge clk_i);
    #1 chk(rdata_o, 32'h0, "rdata idle");
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, d);
    chk(d, 32'h0, "unmapped");
    rd(8'h00, d);
    chk(d, 32'h0, "cfg kept");
    wr(8'h00, 32'h455);
    rd(8'h00, d);
    chk(d, 32'h455, "cfg back");
    $display("test regs done");
  endtask : t_regs

  task automatic t_in();
    wr(8'h00, 32'h0);
    pin(1'h1);
    chk(32'(core_in_o[0]), 32'h1, "plain in");
    chk(32'(bypass_input_o), 32'h1, "bypass hi");
    pin(1'h0);
    chk(32'(bypass_input_o), 32'h0, "bypass lo");
    wr(8'h00, 32'h1);
    fabric_i.cap(1'h1);
    fabric_i.cap(1'h0);
    pin(1'h1);
    chk(32'(bypass_input_o), 32'h0, "bypass off");
    chk(32'(core_in_o[0]), 32'h0, "held");
    fabric_i.lch(1'h1);
    fabric_i.lch(1'h0);
    chk(32'(core_in_o[0]), 32'h0, "launch no capture");
    fabric_i.cap(1'h1);
    chk(32'(core_in_o[0]), 32'h1, "rise capture");
    wr(8'h00, 32'h3);
    pin(1'h0);
    fabric_i.cap(1'h0);
    pin(1'h1);
    fabric_i.cap(1'h1);
    chk(32'(core_in_o[0]), 32'h0, "rise ignored");
    fabric_i.cap(1'h0);
    chk(32'(core_in_o[0]), 32'h1, "fall capture");
    $display("test in done");
  endtask : t_in

  task automatic t_de();
    logic [1:0] v;
    wr(8'h00, 32'h41);
    pin(1'h0);
    fabric_i.cap(1'h1);
    pin(1'h1);
    fabric_i.cap(1'h0);
    chk(32'(core_in_o), 32'h2, "de normal");
    wr(8'h00, 32'hC1);
    fabric_i.cap(1'h1);
    v = core_in_o;
    fabric_i.cap(1'h0);
    chk(32'(core_in_o), 32'(v), "resync fall held");
    pin(1'h0);
    fabric_i.cap(1'h1);
    chk(32'(core_in_o), 32'h2, "resync pair");
    wr(8'h00, 32'h341);
    chk(32'(pull_down_o), 32'h0, "pair no pull");
    fabric_i.cap(1'h0);
    chk(32'(core_in_o[1]), 32'h1, "pair no de");
    wr(8'h00, 32'h241);
    chk(32'(pull_down_o), 32'h1, "pull");
    $display("test de done");
  endtask : t_de

  task automatic t_out();
    logic [31:0] d;
    wr(8'h00, 32'h400);
    fabric_i.drv(2'h1, 1'h1);
    chk(32'(pad_o), 32'h1, "out plain");
    chk(32'(pad_oe_o), 32'h1, "oe on");
    rd(8'h04, d);
    chk(32'(d[1:0]), 32'h3, "status");
    fabric_i.drv(2'h1, 1'h0);
    chk(32'(pad_oe_o), 32'h0, "oe off");
    wr(8'h00, 32'h0);
    fabric_i.drv(2'h1, 1'h1);
    chk(32'(pad_oe_o), 32'h0, "input mode oe");
    wr(8'h00, 32'h424);
    fabric_i.lch(1'h1);
    chk(32'(pad_o), 32'h0, "inverted");
    fabric_i.drv(2'h0, 1'h1);
    chk(32'(pad_o), 32'h0, "out held");
    fabric_i.cap(1'h1);
    fabric_i.cap(1'h0);
    chk(32'(pad_o), 32'h0, "capture no launch");
    fabric_i.lch(1'h0);
    chk(32'(pad_o), 32'h0, "fall ignored");
    fabric_i.lch(1'h1);
    chk(32'(pad_o), 32'h1, "inverted zero");
    wr(8'h00, 32'h444);
    fabric_i.drv(2'h2, 1'h1);
    fabric_i.lch(1'h0);
    chk(32'(pad_o), 32'h1, "de fall half");
    fabric_i.lch(1'h1);
    chk(32'(pad_o), 32'h0, "de rise half");
    wr(8'h00, 32'h4C4);
    fabric_i.drv(2'h1, 1'h1);
    fabric_i.lch(1'h0);
    chk(32'(pad_o), 32'h1, "resync fall half");
    fabric_i.lch(1'h1);
    chk(32'(pad_o), 32'h1, "resync rise half");
    fabric_i.drv(2'h2, 1'h1);
    fabric_i.lch(1'h0);
    chk(32'(pad_o), 32'h0, "resync fall from rise");
    wr(8'h00, 32'h41C);
    fabric_i.drv(2'h1, 1'h0);
    fabric_i.lch(1'h1);
    chk(32'(pad_oe_o), 32'h1, "oe rise ignored");
    fabric_i.lch(1'h0);
    chk(32'(pad_oe_o), 32'h0, "oe reg low");
    fabric_i.drv(2'h1, 1'h1);
    chk(32'(pad_oe_o), 32'h0, "oe reg held");
    fabric_i.lch(1'h1);
    fabric_i.lch(1'h0);
    chk(32'(pad_oe_o), 32'h1, "oe reg set");
    $display("test out done");
  endtask : t_out

  task automatic t_bidir();
    wr(8'h00, 32'h800);
    fabric_i.drv(2'h0, 1'h0);
    pin(1'h1);
    chk(32'(core_in_o[0]), 32'h1, "bidir in");
    fabric_i.drv(2'h0, 1'h1);
    chk(32'(pad_oe_o), 32'h1, "bidir oe");
    chk(32'(core_in_o[0]), 32'h0, "loopback");
    $display("test bidir done");
  endtask : t_bidir

  // Mid-run reset must drop the config and every pad request
  task automatic t_reset();
    logic [31:0] d;
    wr(8'h00, 32'h241);
    chk(32'(pull_down_o), 32'h1, "pull before reset");
    @(posedge clk_i);
    rstn_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'h1;
    @(posedge clk_i);
    #1 chk(32'(pull_down_o), 32'h0, "pull after reset");
    chk(32'(pad_oe_o), 32'h0, "oe after reset");
    rd(8'h00, d);
    chk(d, 32'h0, "cfg after reset");
    $display("test reset done");
  endtask : t_reset

  initial
  begin
    rstn_i  = 1'h0;
    we_i    = 1'h0;
    re_i    = 1'h0;
    addr_i  = 8'h00;
    wdata_i = 32'h0;
    pad_q   = 1'h0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'h1;
    t_regs();
    t_in();
    t_de();
    t_out();
    t_bidir();
    t_reset();
    test_done();
  end
endmodule : tb_top
